/* File: lfsr_crc_consts.svh */
// Offsets, field positions and widths of the shift-register unit.
// Assumes inclusion by bare name from the unit's design and bench files.
`ifndef LFSR_CRC_CONSTS_SVH
`define LFSR_CRC_CONSTS_SVH
// Data-memory addresses of the register window.
`define WIN_HIGH_ADDR      8'h23
`define WIN_LOW_ADDR       8'h27
`define WIN_PTR_ADDR       8'h2b
// Pointer fields: index in 3:0, unit number in 5:4.
`define PTR_INDEX_LSB      0
`define PTR_UNIT_LSB       4
// Register-pair indices.
`define IDX_INPUT          4'h0
`define IDX_OUTPUT         4'h1
`define IDX_FB21           4'h2
`define IDX_CFG2_RES4      4'h3
`define IDX_RES32          4'h4
`define IDX_RES10          4'h5
`define IDX_FB43           4'h6
`define IDX_CFG3_DOUT      4'h7
`define IDX_CFG1_POLY4     4'h8
`define IDX_POLY32         4'h9
`define IDX_POLY10         4'ha
`define IDX_CMP32          4'hb
`define IDX_CMP10          4'hc
// Configuration three bits.
`define C3_AUTOLOAD        5
`define C3_RES_DIR         4
`define C3_IN_DIR          3
`define C3_TRIG_SEL        2
`define C3_TAP3_EN         1
`define C3_TAP4_EN         0
`define C3_USED_MASK       8'h3f
// Configuration one bits.
`define C1_PRESET          6
`define C1_DONE            5
`define C1_MATCH           4
// Configuration two bits.
`define C2_OUTTAP_OUT      7
`define C2_DIN_OUT         6
`define C2_TAP1_OUT        5
`define C2_TAP2_OUT        4
`define C2_DIN_RES         3
`define C2_TAP1_RES        2
`define C2_TAP2_RES        1
`define C2_DIN_POLY        0
// Sizes.
`define RES_BITS           40
`define CMP_BITS           32
`define FIFO_DEPTH         8
`endif

/* File: lfsr_crc_pkg.sv */
// Types used by the shift-register unit.
// Assumes nothing beyond a SystemVerilog compiler.
package lfsr_crc_pkg;
   // Engine states, Gray coded along idle, run, finish.
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_RUN    = 2'b01,
      ST_FINISH = 2'b11
   } engine_state_t;
endpackage

/* File: lfsr_crc_engine_cfg.sv */
// One configurable shift-register unit for CRC and scrambling, with its autoload FIFO.
// Assumes the core writes it through the three-byte window and that the
// receive-buffer strobes come from logic on the same clock.
`include "lfsr_crc_consts.svh"

// Small synchronous FIFO with a registered full flag.
module lfsr_crc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];   // Storage words.
   logic [AW-1:0]    wrPtr;         // Next slot to fill.
   logic [AW-1:0]    rdPtr;         // Oldest slot.
   logic [AW:0]      count;         // Words held.
   logic [AW:0]      next_count;    // Count after this edge.
   logic             push;          // Word accepted.
   logic             pop;           // Word handed out.

   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];

   // Occupancy arithmetic; full is registered so the ready port is a flop.
   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // Pointers, count and the ready flag.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         wrPtr   <= '0;
         rdPtr   <= '0;
         count   <= '0;
         inReady <= 1'b0;
      end else begin
         count   <= next_count;
         inReady <= (next_count != (AW+1)'(DEPTH));
         if (push) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= rdPtr + 1'b1;
         end
      end
   end

   // Storage needs no reset.
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end
endmodule // lfsr_crc_fifo

module lfsr_crc_engine_cfg #(
   parameter logic [1:0] UNIT_NUMBER = 2'h0   // Which of the four units this is.
) (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic [7:0]  busAddr,       // Data-memory address.
   input  wire logic        busWrite,      // One-cycle write strobe.
   input  wire logic        busRead,       // One-cycle read strobe.
   input  wire logic [7:0]  busWrData,
   output logic      [7:0]  busRdData,     // Valid the cycle after busRead.
   input  wire logic        rxLoadFirst,   // First receive buffer loaded.
   input  wire logic [15:0] rxWordFirst,
   input  wire logic        rxLoadSecond,  // Second receive buffer loaded.
   input  wire logic [15:0] rxWordSecond,
   output logic             rxReady,       // Autoload FIFO can take a word.
   output logic             engineBusy     // Operation in progress.
);
   // Bit-reversal helpers, used for both the view and the compare.
   function automatic logic [39:0] rev40(input logic [39:0] v);
      for (int i = 0; i < 40; i++) rev40[i] = v[39-i];
   endfunction
   function automatic logic [31:0] rev32(input logic [31:0] v);
      for (int i = 0; i < 32; i++) rev32[i] = v[31-i];
   endfunction
   // 40:1 tap multiplexer; selects beyond bit 39 give zero.
   function automatic logic tapPick(input logic [39:0] r, input logic [7:0] sel);
      tapPick = (sel < 8'h28) ? r[sel[5:0]] : 1'b0;
   endfunction

   lfsr_crc_pkg::engine_state_t state;   // Engine sequencer.
   logic [7:0]  pointer;          // Window unit and index.
   logic [3:0]  shiftCount;       // Programmed count N.
   logic [7:0]  cfgTwo;           // Gating enables.
   logic [5:0]  cfgThree;         // Only bits 5:0 exist.
   logic [7:0]  tapSel [4];       // Feedback tap selects one to four.
   logic [7:0]  outTapSel;        // Output tap select.
   logic [39:0] poly;             // Polynomial.
   logic [39:0] residue;          // Residue, held in shift order.
   logic [31:0] cmpValue;         // Compare value.
   logic [15:0] inputWord;        // Data in.
   logic [15:0] outputWord;       // Data out.
   logic [3:0]  step;             // Shift number within operation.
   logic        done;             // Completion flag.
   logic        match;            // Compare result.

   logic        myUnit, winHigh, winLow, wrHigh, wrLow;
   logic [3:0]  idx;
   logic        resDir, inDir, trigger, popWord;
   logic        dinBit, tap1, tap2, tap3, tap4, outTap, d0, polyXor;
   logic        leaving, outBit;
   logic [39:0] shifted, resView, next_view;
   logic        fifoValid;
   logic [15:0] fifoWord, rxWord;
   logic        rxLoad;

   assign idx    = pointer[`PTR_INDEX_LSB +: 4];
   assign myUnit = (pointer[`PTR_UNIT_LSB +: 2] == UNIT_NUMBER);
   assign winHigh = myUnit && (busAddr == `WIN_HIGH_ADDR);
   assign winLow  = myUnit && (busAddr == `WIN_LOW_ADDR);
   assign wrHigh  = busWrite && winHigh;
   assign wrLow   = busWrite && winLow;
   assign resDir  = cfgThree[`C3_RES_DIR];
   assign inDir   = cfgThree[`C3_IN_DIR];

   // Even units pair with the first receiver, odd units with the second.
   assign rxLoad = UNIT_NUMBER[0] ? rxLoadSecond : rxLoadFirst;
   assign rxWord = UNIT_NUMBER[0] ? rxWordSecond : rxWordFirst;

   // Autoload words queue here; the engine drains one only when idle, so
   // bursts beyond the depth drop rxReady, and loads offered while it is low are lost.
   lfsr_crc_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH)) autoloadQueue (
      .mclk     (mclk),
      .resetn   (resetn),
      .inValid  (rxLoad && cfgThree[`C3_AUTOLOAD]),
      .inReady  (rxReady),
      .inData   (rxWord),
      .outValid (fifoValid),
      .outReady (popWord),
      .outData  (fifoWord)
   );

   // A queued word is taken only when idle and the core is not writing data-in.
   assign popWord = fifoValid && (state == lfsr_crc_pkg::ST_IDLE)
                    && !((wrHigh || wrLow) && idx == `IDX_INPUT);

   // Start on the selected byte write, or on an autoloaded word.
   assign trigger = popWord
                    || (idx == `IDX_INPUT && (cfgThree[`C3_TRIG_SEL] ? wrHigh : wrLow));

   // Serial sources for this step.
   assign dinBit = inputWord[inDir ? (4'hf - step) : step];
   assign tap1   = tapPick(residue, tapSel[0]);
   assign tap2   = tapPick(residue, tapSel[1]);
   assign tap3   = tapPick(residue, tapSel[2]);
   assign tap4   = tapPick(residue, tapSel[3]);
   assign outTap = tapPick(residue, outTapSel);
   assign leaving = resDir ? residue[39] : residue[0];

   // Residue input node: XOR of every enabled source.
   assign d0 = (cfgTwo[`C2_DIN_RES] & dinBit) ^ (cfgTwo[`C2_TAP1_RES] & tap1)
             ^ (cfgTwo[`C2_TAP2_RES] & tap2)
             ^ (cfgThree[`C3_TAP3_EN] & tap3)
             ^ (cfgThree[`C3_TAP4_EN] & tap4);
   // Polynomial gate: the leaving bit, optionally mixed with data-in.
   assign polyXor = leaving ^ (cfgTwo[`C2_DIN_POLY] & dinBit);
   // Output stream bit.
   assign outBit = leaving ^ (cfgTwo[`C2_OUTTAP_OUT] & outTap)
                 ^ (cfgTwo[`C2_DIN_OUT] & dinBit)
                 ^ (cfgTwo[`C2_TAP1_OUT] & tap1) ^ (cfgTwo[`C2_TAP2_OUT] & tap2);

   // One shift, with the polynomial applied when the gate is high.
   assign shifted = (resDir ? {residue[38:0], d0} : {d0, residue[39:1]})
                    ^ (polyXor ? poly : 40'h0);

   // Software sees the residue bit-reversed when the direction bit is set.
   assign resView = resDir ? rev40(residue) : residue;

   // Byte-wise write into the software view of the residue.
   always_comb begin
      next_view = resView;
      if (wrLow && idx == `IDX_CFG2_RES4) next_view[39:32] = busWrData;
      else if (wrHigh && idx == `IDX_RES32) next_view[31:24] = busWrData;
      else if (wrLow && idx == `IDX_RES32) next_view[23:16] = busWrData;
      else if (wrHigh && idx == `IDX_RES10) next_view[15:8] = busWrData;
      else if (wrLow && idx == `IDX_RES10) next_view[7:0] = busWrData;
   end

   // Window pointer.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         pointer <= 8'h00;
      end else if (busWrite && busAddr == `WIN_PTR_ADDR) begin
         pointer <= busWrData;
      end
   end

   // Configuration, tap and compare registers written through the window.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         shiftCount <= 4'h0;
         cfgTwo     <= 8'h00;
         cfgThree   <= 6'h00;
         outTapSel  <= 8'h00;
         poly       <= 40'h0;
         cmpValue   <= 32'h0;
         for (int i = 0; i < 4; i++) tapSel[i] <= 8'h00;
      end else if (wrHigh) begin
         if (idx == `IDX_FB21) tapSel[1] <= busWrData;
         else if (idx == `IDX_CFG2_RES4) cfgTwo <= busWrData;
         else if (idx == `IDX_FB43) tapSel[3] <= busWrData;
         else if (idx == `IDX_CFG3_DOUT) cfgThree <= busWrData[5:0];
         else if (idx == `IDX_CFG1_POLY4) shiftCount <= busWrData[3:0];
         else if (idx == `IDX_POLY32) poly[31:24] <= busWrData;
         else if (idx == `IDX_POLY10) poly[15:8] <= busWrData;
         else if (idx == `IDX_CMP32) cmpValue[31:24] <= busWrData;
         else if (idx == `IDX_CMP10) cmpValue[15:8] <= busWrData;
      end else if (wrLow) begin
         if (idx == `IDX_FB21) tapSel[0] <= busWrData;
         else if (idx == `IDX_FB43) tapSel[2] <= busWrData;
         else if (idx == `IDX_CFG3_DOUT) outTapSel <= busWrData;
         else if (idx == `IDX_CFG1_POLY4) poly[39:32] <= busWrData;
         else if (idx == `IDX_POLY32) poly[23:16] <= busWrData;
         else if (idx == `IDX_POLY10) poly[7:0] <= busWrData;
         else if (idx == `IDX_CMP32) cmpValue[23:16] <= busWrData;
         else if (idx == `IDX_CMP10) cmpValue[7:0] <= busWrData;
      end
   end

   // Data-in: separate byte writes, or a whole autoloaded word.
   always_ff @(posedge mclk) begin
      if (!resetn) inputWord <= 16'h0000;
      else if (popWord) inputWord <= fifoWord;
      else if (wrHigh && idx == `IDX_INPUT) inputWord[15:8] <= busWrData;
      else if (wrLow && idx == `IDX_INPUT) inputWord[7:0] <= busWrData;
   end

   // Data-out: the engine shifts in at the top, so after N+1 shifts the first bit sits at bit 15-N.
   always_ff @(posedge mclk) begin
      if (!resetn) outputWord <= 16'h0000;
      else if (state == lfsr_crc_pkg::ST_RUN) outputWord <= {outBit, outputWord[15:1]};
      else if (wrHigh && idx == `IDX_OUTPUT) outputWord[15:8] <= busWrData;
      else if (wrLow && idx == `IDX_OUTPUT) outputWord[7:0] <= busWrData;
   end

   // Residue: the running engine owns it, so core writes in ST_RUN are dropped.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         residue <= 40'h0;
      end else if (state == lfsr_crc_pkg::ST_RUN) begin
         residue <= shifted;
      end else if (wrHigh && idx == `IDX_CFG1_POLY4 && busWrData[`C1_PRESET]) begin
         residue <= {40{1'b1}};
      end else begin
         residue <= resDir ? rev40(next_view) : next_view;
      end
   end

   // Sequencer: N+1 shifts, then one cycle to settle the compare.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state      <= lfsr_crc_pkg::ST_IDLE;
         step       <= 4'h0;
         done       <= 1'b1;
         match      <= 1'b0;
         engineBusy <= 1'b0;
      end else begin
         case (state)
            lfsr_crc_pkg::ST_IDLE: begin
               if (trigger) begin
                  state      <= lfsr_crc_pkg::ST_RUN;
                  step       <= 4'h0;
                  done       <= 1'b0;
                  engineBusy <= 1'b1;
               end
            end
            lfsr_crc_pkg::ST_RUN: begin
               if (step == shiftCount) begin
                  state <= lfsr_crc_pkg::ST_FINISH;
               end else begin
                  step <= step + 4'h1;
               end
            end
            lfsr_crc_pkg::ST_FINISH: begin
               // Reversed upper 32 bits when clear, low 32 direct when set.
               match <= resDir ? (residue[31:0] == cmpValue)
                               : (rev32(residue[39:8]) == cmpValue);
               done       <= 1'b1;
               engineBusy <= 1'b0;
               state      <= lfsr_crc_pkg::ST_IDLE;
            end
            default: begin
               state <= lfsr_crc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Read port: one cycle of latency; a foreign unit or address reads zero.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         busRdData <= 8'h00;
      end else if (busRead && busAddr == `WIN_PTR_ADDR) begin
         busRdData <= pointer;
      end else if (busRead && winHigh) begin
         if (idx == `IDX_INPUT) busRdData <= inputWord[15:8];
         else if (idx == `IDX_OUTPUT) busRdData <= outputWord[15:8];
         else if (idx == `IDX_FB21) busRdData <= tapSel[1];
         else if (idx == `IDX_CFG2_RES4) busRdData <= cfgTwo;
         else if (idx == `IDX_RES32) busRdData <= resView[31:24];
         else if (idx == `IDX_RES10) busRdData <= resView[15:8];
         else if (idx == `IDX_FB43) busRdData <= tapSel[3];
         else if (idx == `IDX_CFG3_DOUT) busRdData <= {2'b00, cfgThree};
         else if (idx == `IDX_CFG1_POLY4) busRdData <= {2'b00, done, match, shiftCount};
         else if (idx == `IDX_POLY32) busRdData <= poly[31:24];
         else if (idx == `IDX_POLY10) busRdData <= poly[15:8];
         else if (idx == `IDX_CMP32) busRdData <= cmpValue[31:24];
         else if (idx == `IDX_CMP10) busRdData <= cmpValue[15:8];
         else busRdData <= 8'h00;
      end else if (busRead && winLow) begin
         if (idx == `IDX_INPUT) busRdData <= inputWord[7:0];
         else if (idx == `IDX_OUTPUT) busRdData <= outputWord[7:0];
         else if (idx == `IDX_FB21) busRdData <= tapSel[0];
         else if (idx == `IDX_CFG2_RES4) busRdData <= resView[39:32];
         else if (idx == `IDX_RES32) busRdData <= resView[23:16];
         else if (idx == `IDX_RES10) busRdData <= resView[7:0];
         else if (idx == `IDX_FB43) busRdData <= tapSel[2];
         else if (idx == `IDX_CFG3_DOUT) busRdData <= outTapSel;
         else if (idx == `IDX_CFG1_POLY4) busRdData <= poly[39:32];
         else if (idx == `IDX_POLY32) busRdData <= poly[23:16];
         else if (idx == `IDX_POLY10) busRdData <= poly[7:0];
         else if (idx == `IDX_CMP32) busRdData <= cmpValue[23:16];
         else if (idx == `IDX_CMP10) busRdData <= cmpValue[7:0];
         else busRdData <= 8'h00;
      end else begin
         busRdData <= 8'h00;
      end
   end
endmodule // lfsr_crc_engine_cfg

/* File: lfsr_crc_engine_cfg_checker.sv */
// Port-level assertions for one shift-register unit.
// Assumes a bind from the bench and a single clock domain.
`include "lfsr_crc_consts.svh"
module lfsr_crc_engine_cfg_checker #(
   parameter logic [1:0] UNIT_NUMBER = 2'h0
) (
   input wire logic       mclk,
   input wire logic       resetn,
   input wire logic [7:0] busAddr,
   input wire logic       busWrite,
   input wire logic       busRead,
   input wire logic [7:0] busWrData,
   input wire logic [7:0] busRdData,
   input wire logic       rxLoadFirst,
   input wire logic       rxLoadSecond,
   input wire logic       rxReady,
   input wire logic       engineBusy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic [7:0] ptr;     // Shadow of the shared window pointer.
   logic [7:0] cfg3;    // Shadow of configuration three.
   logic       dinWr;   // Idle data-in write with autoload off.
   logic       ownLoad; // Load strobe of the paired receiver.
   assign ownLoad = UNIT_NUMBER[0] ? rxLoadSecond : rxLoadFirst;
   assign dinWr = busWrite && ptr[5:0] == {UNIT_NUMBER, `IDX_INPUT} && !engineBusy && !cfg3[5];
   // The pointer is shared by all units, so every write to it is followed.
   always_ff @(posedge mclk) begin
      if (!resetn) ptr <= 8'h00;
      else if (busWrite && busAddr == `WIN_PTR_ADDR) ptr <= busWrData;
   end
   // Configuration three changes only when this unit owns the pointer.
   always_ff @(posedge mclk) begin
      if (!resetn) cfg3 <= 8'h00;
      else if (busWrite && busAddr == `WIN_HIGH_ADDR && ptr[5:0] == {UNIT_NUMBER, `IDX_CFG3_DOUT})
         cfg3 <= busWrData;
   end
   sequence s_run; engineBusy [*2]; endsequence
   sequence s_relax; !rxReady ##1 rxReady; endsequence
   property p_rdIdle; !$past(busRead) |-> busRdData == 8'h00; endproperty
   property p_trig; dinWr && busAddr == (cfg3[2] ? `WIN_HIGH_ADDR : `WIN_LOW_ADDR) |=> engineBusy;
   endproperty
   property p_noTrig; dinWr && busAddr == (cfg3[2] ? `WIN_LOW_ADDR : `WIN_HIGH_ADDR) |=> !engineBusy;
   endproperty
   property p_busyMin; $rose(engineBusy) |-> s_run; endproperty
   property p_busyMax; $rose(engineBusy) |-> ##[1:17] !engineBusy; endproperty
   property p_rdyRst; $rose(resetn) |-> s_relax; endproperty
   property p_idleRst; $rose(resetn) |-> !engineBusy; endproperty
   property p_rxFall; $fell(rxReady) |-> $past(ownLoad) || $past(ownLoad, 2); endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data without read");
   a_trig: assert property (p_trig) else $error("trigger byte did not start");
   a_noTrig: assert property (p_noTrig) else $error("other byte started");
   a_busyMin: assert property (p_busyMin) else $error("run too short");
   a_busyMax: assert property (p_busyMax) else $error("run too long");
   a_rdyRst: assert property (p_rdyRst) else $error("ready after reset");
   a_idleRst: assert property (p_idleRst) else $error("busy after reset");
   a_rxFall: assert property (p_rxFall) else $error("full without own load");
endmodule // lfsr_crc_engine_cfg_checker

/* File: lfsr_crc_rx_model.sv */
// Receive-buffer model feeding the unit's autoload path.
// Assumes the bench calls send and reads the two counters.
module lfsr_crc_rx_model (
   input  wire logic        mclk,
   input  wire logic        rxReady,
   output logic             rxLoadFirst,
   output logic      [15:0] rxWordFirst,
   output logic             rxLoadSecond,
   output logic      [15:0] rxWordSecond
);
   timeunit 1ns;
   timeprecision 1ps;
   int accepted = 0; // First-line loads taken while ready.
   int refused  = 0; // First-line loads offered while full.
   initial begin
      rxLoadFirst  = 1'b0;
      rxLoadSecond = 1'b0;
      rxWordFirst  = 16'h0000;
      rxWordSecond = 16'h0000;
   end
   // A real receiver never waits for room, so loads go out blindly.
   task automatic send(input logic second, input logic [15:0] w, input int cnt);
      for (int i = 0; i < cnt; i++) begin
         @(posedge mclk);
         rxLoadFirst  <= !second;
         rxLoadSecond <= second;
         rxWordFirst  <= second ? ~w : w;
         rxWordSecond <= second ? w : ~w;
      end
      @(posedge mclk);
      rxLoadFirst  <= 1'b0;
      rxLoadSecond <= 1'b0;
      // The buffer is not held after its strobe, so show the inverse.
      rxWordFirst  <= ~w;
      rxWordSecond <= ~w;
   endtask
   // Tally first-line loads as the unit samples them.
   always @(posedge mclk) begin
      if (rxLoadFirst === 1'b1 && rxReady === 1'b1) accepted++;
      else if (rxLoadFirst === 1'b1) refused++;
   end
endmodule // lfsr_crc_rx_model

/* File: testbench.sv */
// Self-checking bench for shift-register unit 0 and its receive feed.
// Assumes the checker and receive model files compile first.
`include "lfsr_crc_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;      // Core clock, 250 MHz.
   logic        resetn = 1'b0;    // Held low for two cycles.
   logic [7:0]  busAddr = 8'h00;
   logic        busWrite = 1'b0;
   logic        busRead = 1'b0;
   logic [7:0]  busWrData = 8'h00;
   logic [7:0]  busRdData;
   logic        rxLoadFirst, rxLoadSecond, rxReady, engineBusy;
   logic [15:0] rxWordFirst, rxWordSecond;
   logic        busyQ = 1'b0;     // Busy one edge earlier.
   int          err_total = 0;
   int          tests_run = 0;
   int          starts = 0;       // Operations started so far.
   int          n0, a0, r0;       // Snapshots of the counters.
   logic [39:0] res = 40'h0;      // Expected internal residue.
   logic [15:0] dout = 16'h0;     // Expected data-out word.
   logic [15:0] v;                // Word read back.
   always #2 mclk = ~mclk;
   // Count starts; the values read are those before this edge.
   always @(posedge mclk) begin
      if (engineBusy === 1'b1 && busyQ === 1'b0) starts++;
      busyQ <= engineBusy;
   end
   lfsr_crc_engine_cfg #(.UNIT_NUMBER(2'h0)) dut_u (.mclk(mclk), .resetn(resetn),
      .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead), .busWrData(busWrData),
      .busRdData(busRdData), .rxLoadFirst(rxLoadFirst), .rxWordFirst(rxWordFirst),
      .rxLoadSecond(rxLoadSecond), .rxWordSecond(rxWordSecond), .rxReady(rxReady),
      .engineBusy(engineBusy));
   lfsr_crc_rx_model rx_u (.mclk(mclk), .rxReady(rxReady), .rxLoadFirst(rxLoadFirst),
      .rxWordFirst(rxWordFirst), .rxLoadSecond(rxLoadSecond), .rxWordSecond(rxWordSecond));
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   // One-cycle write strobe; a gap cycle keeps strobes from colliding.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      busAddr <= a;
      busWrData <= d;
      busWrite <= 1'b1;
      @(posedge mclk);
      busWrite <= 1'b0;
   endtask
   // Read data stands for one cycle after the read edge only.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      busAddr <= a;
      busRead <= 1'b1;
      @(posedge mclk);
      busRead <= 1'b0;
      #1 d = busRdData;
   endtask
   task automatic pair(input logic [7:0] p, input logic [7:0] h, input logic [7:0] l);
      wr(`WIN_PTR_ADDR, p);
      wr(`WIN_HIGH_ADDR, h);
      wr(`WIN_LOW_ADDR, l);
   endtask
   task automatic rpair(input logic [7:0] p, output logic [15:0] d);
      wr(`WIN_PTR_ADDR, p);
      rd(`WIN_HIGH_ADDR, d[15:8]);
      rd(`WIN_LOW_ADDR, d[7:0]);
   endtask
   // Idle means busy low for four samples, so a queued word has had time to start.
   task automatic idle();
      int q;
      q = 0;
      for (int k = 0; k < 400; k++) begin
         @(posedge mclk);
         #1;
         q = (engineBusy === 1'b0) ? q + 1 : 0;
         if (q > 3 && rxReady === 1'b1) return;
      end
      err_total++;
      end_of_test();
   endtask
   function automatic logic [39:0] rev40(input logic [39:0] x);
      for (int i = 0; i < 40; i++) rev40[i] = x[39 - i];
   endfunction
   // Reference shifting with only data-in, taps three and four, and out tap 7.
   function automatic void step(input logic [7:0] c3, input logic [7:0] c2,
                                input logic [3:0] n, input logic [15:0] d);
      logic b;
      logic o;
      for (int s = 0; s <= n; s++) begin
         b = (c3[3] ? d[15 - s] : d[s]) ^ ((c3[1] ^ c3[0]) & res[7]);
         o = (c3[4] ? res[39] : res[0]) ^ (c2[7] & res[7]);
         dout = {o, dout[15:1]};
         res = c3[4] ? {res[38:0], b} : {b, res[39:1]};
      end
   endfunction
   task automatic checkRes(input logic dir);
      logic [39:0] x;
      x = dir ? rev40(res) : res;
      rpair(8'h03, v); chk(v[7:0], x[39:32]);
      rpair(8'h04, v); chk(v, x[31:16]);
      rpair(8'h05, v); chk(v, x[15:0]);
      rpair(8'h01, v); chk(v, dout);
   endtask
   task automatic op(input int i, input logic [7:0] c3, input logic [3:0] n,
                     input logic [15:0] d);
      logic [7:0]  c2;
      logic [39:0] r;
      logic [31:0] m;
      c2 = i[0] ? 8'h88 : 8'h08;
      r = 40'h12_3456_789a ^ 40'(i);
      pair(8'h07, c3, 8'h07);
      pair(8'h08, {4'h0, n}, 8'h00);
      pair(8'h03, c2, r[39:32]);
      pair(8'h04, r[31:24], r[23:16]);
      pair(8'h05, r[15:8], r[7:0]);
      res = c3[4] ? rev40(r) : r;
      step(c3, c2, n, d);
      r = rev40(res);
      m = c3[4] ? res[31:0] : r[31:0];
      if (i[0]) m = ~m;
      pair(8'h0b, m[31:24], m[23:16]);
      pair(8'h0c, m[15:8], m[7:0]);
      wr(`WIN_PTR_ADDR, 8'h00);
      wr(c3[2] ? `WIN_LOW_ADDR : `WIN_HIGH_ADDR, c3[2] ? d[7:0] : d[15:8]);
      wr(c3[2] ? `WIN_HIGH_ADDR : `WIN_LOW_ADDR, c3[2] ? d[15:8] : d[7:0]);
      idle();
      rpair(8'h08, v); chk(v[15:8], {3'b001, !i[0], n});
      rpair(8'h07, v); chk(v[15:8], c3 & 8'h3f);
      checkRes(c3[4]);
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      rpair(8'h08, v); chk(v[15:8], 8'h20);
      pair(8'h08, 8'h40, 8'h00);
      rpair(8'h08, v); chk(v[15:8], 8'h20);
      rpair(8'h04, v); chk(v, 16'hffff);
      pair(8'h17, 8'hff, 8'hff);
      rpair(8'h17, v); chk(v, 16'h0000);
      rpair(8'h07, v); chk(v, 16'h0000);
      rpair(8'h0f, v); chk(v, 16'h0000);
      for (int k = 9; k < 13; k++) begin
         pair(8'(k), 8'(k) ^ 8'h5a, 8'(k) ^ 8'ha5);
         rpair(8'(k), v); chk(v, {8'(k) ^ 8'h5a, 8'(k) ^ 8'ha5});
      end
      pair(8'h09, 8'h00, 8'h00);
      pair(8'h0a, 8'h00, 8'h00);
      pair(8'h06, 8'h07, 8'h07);
      $display("test registers done");
      op(0, 8'h00, 4'hf, 16'h8001);
      op(1, 8'h1e, 4'h3, 16'ha5c3);
      op(2, 8'h09, 4'h0, 16'h1234);
      op(3, 8'h16, 4'h7, 16'hf00f);
      op(4, 8'hc3, 4'hf, 16'h5a5a);
      $display("test operations done");
      pair(8'h07, 8'h20, 8'h07);
      n0 = starts;
      rx_u.send(1'b1, 16'h3c3c, 1);
      idle(); chk(starts - n0, 0);
      rx_u.send(1'b0, 16'h0ff0, 1);
      idle(); chk(starts - n0, 1);
      step(8'h20, 8'h08, 4'hf, 16'h0ff0);
      checkRes(1'b0);
      pair(8'h07, 8'h00, 8'h07);
      rx_u.send(1'b0, 16'h1111, 1);
      idle(); chk(starts - n0, 1);
      pair(8'h07, 8'h20, 8'h07);
      a0 = rx_u.accepted;
      r0 = rx_u.refused;
      n0 = starts;
      rx_u.send(1'b0, 16'hc001, 11);
      idle(); chk(starts - n0, rx_u.accepted - a0);
      chk(rx_u.refused > r0, 1);
      for (int k = a0; k < rx_u.accepted; k++) step(8'h20, 8'h08, 4'hf, 16'hc001);
      checkRes(1'b0);
      $display("test autoload done");
      end_of_test();
   end
endmodule // testbench
bind lfsr_crc_engine_cfg lfsr_crc_engine_cfg_checker #(.UNIT_NUMBER(UNIT_NUMBER)) chk_u (
   .mclk(mclk), .resetn(resetn), .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead),
   .busWrData(busWrData), .busRdData(busRdData), .rxLoadFirst(rxLoadFirst),
   .rxLoadSecond(rxLoadSecond), .rxReady(rxReady), .engineBusy(engineBusy));
